// ### pic_pkg.sv
// Constants, types and field layouts of the eight-input priority interrupt controller.
package pic_pkg;
   // ==========================================================================
   // Sizes.
   localparam int NUM_REQ = 8;
   localparam int CODE_W = 3;
   localparam int GRP_W = 2;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   // ==========================================================================
   // Port indices; the byte address is four times the index.
   localparam logic [7:0] PORT_BASE_DEF = 8'hCC;
   localparam logic [1:0] PORT_MASK = 2'h0;
   localparam logic [1:0] PORT_VEC = 2'h1;
   localparam logic [1:0] PORT_CTL = 2'h2;
   localparam logic [1:0] PORT_SPARE = 2'h3;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;
   localparam int HI_LSB = 10;
   // ==========================================================================
   // Control port fields and reset values.
   localparam int CTL_CARD = 0;
   localparam int CTL_LOWER = 1;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] HOLD_RST = 8'h00;
   localparam logic [1:0] CTL_RST = 2'h0;
   // ==========================================================================
   // Restart instruction layout.
   localparam logic [1:0] RST_HI = 2'h3;
   localparam logic [2:0] RST_LO = 3'h7;
   localparam logic [7:0] NO_REQ_BYTE = 8'h00;
   // ==========================================================================
   // Synchroniser lanes.
   localparam int SYN_W = 11;
   localparam int LANE_ACK = 8;
   localparam int LANE_FRZ = 9;
   localparam int LANE_CHAIN = 10;
   localparam logic [10:0] SYN_RST = 11'h7FF;

   typedef struct packed {
      logic vec_sel;
      logic [1:0] vec_group;
      logic poll_port;
      logic no_autoclear;
      logic no_chain;
      logic use_nmi;
   } pic_strap_t;

   localparam pic_strap_t STRAP_RST = '0;
endpackage

// ### pic_card.sv
// Eight-input priority interrupt controller with an APB register port.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pic_card #(
   parameter int ADDR_W = 12,
   parameter logic [7:0] PORT_BASE = pic_pkg::PORT_BASE_DEF,
   // Vector table contents, entry k in bits 8k+7..8k; default content is all zeros.
   parameter logic [255:0] VEC_TABLE = '0
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request inputs and their capture outputs.
   input wire logic [7:0] irq_request_in_n,
   output logic [7:0] request_captured_out_n,
   // Processor side.
   input wire logic intack_n,
   input wire logic spare_freeze_n,
   output logic int_req_o,
   output logic int_req_oe,
   output logic nmi_req_o,
   output logic nmi_req_oe,
   output logic [7:0] ack_data_o,
   output logic ack_data_oe,
   // Priority chain.
   input wire logic chain_in,
   output logic chain_out,
   // Straps.
   input wire pic_pkg::pic_strap_t straps
);
   // ==========================================================================
   // Elaboration checks.
   initial begin
      if (ADDR_W <= pic_pkg::HI_LSB) begin
         $error("ADDR_W must exceed 10");
      end
      if (PORT_BASE[1:0] != 2'h0) begin
         $error("PORT_BASE must be a multiple of four");
      end
   end

   // ==========================================================================
   // Input synchronisers.
   logic [10:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next;
   wire logic [10:0] syn_in = {chain_in, spare_freeze_n, intack_n, irq_request_in_n};
   wire logic [10:0] agree = ~(s2_reg ^ s3_reg);
   wire logic [10:0] fall = stable_reg & ~s2_reg & agree;
   wire logic [10:0] rise = ~stable_reg & s2_reg & agree;
   assign stable_next = (s2_reg & agree) | (stable_reg & ~agree);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= pic_pkg::SYN_RST;
         s2_reg <= pic_pkg::SYN_RST;
         s3_reg <= pic_pkg::SYN_RST;
         stable_reg <= pic_pkg::SYN_RST;
      end else begin
         s1_reg <= syn_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         stable_reg <= stable_next;
      end
   end

   // ==========================================================================
   // Strap capture after reset release.
   pic_pkg::pic_strap_t strap_reg;
   logic strap_done_reg;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_reg <= pic_pkg::STRAP_RST;
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_reg <= straps;
         strap_done_reg <= 1'b1;
      end
   end

   // ==========================================================================
   // APB decode.
   wire logic [7:0] port_idx = paddr[pic_pkg::IDX_MSB:pic_pkg::IDX_LSB];
   wire logic hi_zero = (paddr[ADDR_W-1:pic_pkg::HI_LSB] == '0);
   wire logic hit = hi_zero && (port_idx[7:2] == PORT_BASE[7:2]);
   wire logic [1:0] port_sel = port_idx[1:0];
   wire logic access = psel && penable;
   wire logic wr_ev = access && pwrite && hit;
   wire logic rd_ev = access && !pwrite && hit;
   wire logic rd_pend = psel && !pwrite && hit;
   wire logic wr_mask = wr_ev && (port_sel == pic_pkg::PORT_MASK);
   wire logic wr_hold = wr_ev && (port_sel == pic_pkg::PORT_VEC);
   wire logic wr_ctl = wr_ev && (port_sel == pic_pkg::PORT_CTL);
   wire logic poll_rd = rd_ev && (port_sel == pic_pkg::PORT_VEC) && strap_reg.poll_port;

   // ==========================================================================
   // Control ports.
   logic [7:0] mask_reg, hold_reg, latch_reg, latch_next;
   logic [1:0] ctl_reg, ctl_next;
   logic [2:0] frz_code_reg;
   logic frz_any_reg, frz_req_reg, frz_chain_reg;

   wire logic ack_now = !stable_reg[pic_pkg::LANE_ACK];
   wire logic ack_end = rise[pic_pkg::LANE_ACK];
   wire logic auto_ev = (ack_end || poll_rd) && !strap_reg.no_autoclear && frz_any_reg;

   // Unless auto clear or the chain is strapped off, lower cards stay blocked after a service until software clears the bit.
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next = pwdata[1:0];
      end
      if (auto_ev) begin
         ctl_next[pic_pkg::CTL_LOWER] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_reg <= pic_pkg::MASK_RST;
         hold_reg <= pic_pkg::HOLD_RST;
         ctl_reg <= pic_pkg::CTL_RST;
      end else begin
         if (wr_mask) begin
            mask_reg <= pwdata[7:0];
         end
         if (wr_hold) begin
            hold_reg <= pwdata[7:0];
         end
         ctl_reg <= ctl_next;
      end
   end

   // ==========================================================================
   // Request latches.
   genvar gi;
   generate
      for (gi = 0; gi < pic_pkg::NUM_REQ; gi++) begin : g_latch
         wire logic set_i = fall[gi] && hold_reg[gi];
         wire logic auto_i = auto_ev && (frz_code_reg == 3'(gi));
         assign latch_next[gi] = set_i || (latch_reg[gi] && hold_reg[gi] && !auto_i);
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_reg <= '0;
      end else begin
         latch_reg <= latch_next;
      end
   end

   assign request_captured_out_n = ~latch_reg;

   // ==========================================================================
   // Priority, chain and freeze.
   wire logic [7:0] enabled = latch_reg & mask_reg;
   logic [2:0] win_code;
   always_comb begin
      win_code = '0;
      for (int i = pic_pkg::NUM_REQ - 1; i >= 0; i--) begin
         if (enabled[i]) begin
            win_code = i[2:0];
         end
      end
   end

   wire logic chain_sync = stable_reg[pic_pkg::LANE_CHAIN];
   wire logic chain_eff = strap_reg.no_chain || chain_sync;
   wire logic card_on = chain_eff && !ctl_reg[pic_pkg::CTL_CARD];
   wire logic req_now = (|enabled) && card_on;
   wire logic chain_now = strap_reg.no_chain ? chain_sync :
      (chain_eff && !req_now && !ctl_reg[pic_pkg::CTL_LOWER]);
   wire logic freeze_now = ack_now || rd_pend || !stable_reg[pic_pkg::LANE_FRZ];

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         frz_code_reg <= '0;
         frz_any_reg <= 1'b0;
         frz_req_reg <= 1'b0;
         frz_chain_reg <= 1'b0;
      end else if (!freeze_now) begin
         frz_code_reg <= win_code;
         frz_any_reg <= |enabled;
         frz_req_reg <= req_now;
         frz_chain_reg <= chain_now;
      end
   end

   assign chain_out = frz_chain_reg;
   assign int_req_o = 1'b0;
   assign nmi_req_o = 1'b0;
   assign int_req_oe = frz_req_reg && !strap_reg.use_nmi;
   assign nmi_req_oe = frz_req_reg && strap_reg.use_nmi;

   // ==========================================================================
   // Response generators.
   wire logic [7:0] restart_byte = {pic_pkg::RST_HI, frz_code_reg, pic_pkg::RST_LO};
   wire logic [4:0] vec_idx = {strap_reg.vec_group, frz_code_reg};
   wire logic [7:0] vec_byte = VEC_TABLE[{vec_idx, 3'h0} +: pic_pkg::BYTE_W];
   wire logic [7:0] resp_byte = !frz_any_reg ? pic_pkg::NO_REQ_BYTE :
      (strap_reg.vec_sel ? vec_byte : restart_byte);
   logic [7:0] ack_data_reg;
   logic ack_oe_reg;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_data_reg <= pic_pkg::NO_REQ_BYTE;
         ack_oe_reg <= 1'b0;
      end else begin
         ack_data_reg <= resp_byte;
         ack_oe_reg <= ack_now && !strap_reg.poll_port;
      end
   end

   assign ack_data_o = ack_data_reg;
   assign ack_data_oe = ack_oe_reg;

   // ==========================================================================
   // APB read data.
   wire logic [7:0] rd_byte =
      (port_sel == pic_pkg::PORT_MASK) ? latch_reg :
      ((port_sel == pic_pkg::PORT_VEC) && strap_reg.poll_port) ? resp_byte :
      pic_pkg::NO_REQ_BYTE;
   assign prdata = (psel && !pwrite && hit) ? {24'h000000, rd_byte} : 32'h00000000;
   assign pready = 1'b1;
   assign pslverr = access && !hit;

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   chk_hold_clears: assert property (!hold_reg[3] |=> !latch_reg[3])
      else $error("held latch was set");

   chk_edge_sets: assert property (fall[5] && hold_reg[5] |=> latch_reg[5] && !request_captured_out_n[5])
      else $error("falling edge did not set latch");

   chk_no_spurious: assert property (!fall[2] && !latch_reg[2] |=> !latch_reg[2])
      else $error("latch set without an edge");

   chk_mask_blocks: assert property (((mask_reg == 8'h00) && !freeze_now)[*2] |=> !int_req_oe && !nmi_req_oe)
      else $error("masked card requested");

   chk_poll_true: assert property (rd_ev && port_sel == pic_pkg::PORT_MASK |-> prdata[7:0] == latch_reg)
      else $error("poll did not return latches");

   chk_freeze_holds: assert property (freeze_now |=> $stable(frz_code_reg) && $stable(chain_out))
      else $error("state changed while frozen");

   chk_restart_form: assert property (frz_any_reg && !strap_reg.vec_sel ##1 $stable(frz_code_reg)
      |-> ack_data_reg[7:6] == 2'h3 && ack_data_reg[2:0] == 3'h7 && ack_data_reg[5:3] == frz_code_reg)
      else $error("restart byte malformed");

   chk_auto_clear: assert property (auto_ev && !fall[frz_code_reg] |=> !latch_reg[$past(frz_code_reg)])
      else $error("answered latch not cleared");

   chk_chain_drop: assert property (frz_req_reg && !strap_reg.no_chain |-> !chain_out)
      else $error("chain passed while requesting");

   chk_chain_gate: assert property ((!chain_eff && !freeze_now)[*2] |=> !int_req_oe && !nmi_req_oe)
      else $error("request without chain input");

   chk_unmapped_err: assert property (access && !hit |-> pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");

   chk_latch_keeps: assert property (latch_reg[0] && hold_reg[0] && !auto_ev
      |=> latch_reg[0])
      else $error("set latch lost without a clear");

   chk_edge_top: assert property (fall[0] && hold_reg[0]
      |=> latch_reg[0])
      else $error("falling edge did not set top latch");

   chk_hold_wins: assert property (!hold_reg[0] && fall[0]
      |=> !latch_reg[0])
      else $error("held latch took an edge");

   chk_poll_clear: assert property (poll_rd && !strap_reg.no_autoclear && frz_any_reg && !fall[frz_code_reg]
      |=> !latch_reg[$past(frz_code_reg)])
      else $error("port read did not clear latch");

   chk_noauto_keeps: assert property (strap_reg.no_autoclear && latch_reg[3] && hold_reg[3]
      |=> latch_reg[3])
      else $error("latch cleared with auto clear off");

   chk_mask_keeps: assert property (!mask_reg[4] && fall[4] && hold_reg[4]
      |=> latch_reg[4])
      else $error("masked latch not set");

   chk_top_wins: assert property (!freeze_now && enabled[0]
      |=> frz_code_reg == 3'h0)
      else $error("top input did not win");

   chk_req_line: assert property (!freeze_now && req_now && !strap_reg.use_nmi
      |=> int_req_oe)
      else $error("request line not driven");

   chk_nmi_route: assert property (frz_req_reg
      |-> int_req_oe != nmi_req_oe)
      else $error("request not on exactly one line");

   chk_ack_drive: assert property (ack_now && !strap_reg.poll_port
      |=> ack_data_oe)
      else $error("response not driven in acknowledge");

   chk_ack_quiet: assert property (!ack_now
      |=> !ack_data_oe)
      else $error("response driven outside acknowledge");

   chk_ack_code: assert property (ack_data_oe && frz_any_reg && !strap_reg.vec_sel && $stable(frz_code_reg)
      && $stable(frz_any_reg) |-> ack_data_o[5:3] == frz_code_reg)
      else $error("restart level wrong");

   chk_port_code: assert property (rd_ev && port_sel == pic_pkg::PORT_VEC && strap_reg.poll_port
      && !strap_reg.vec_sel && frz_any_reg |-> prdata[5:3] == frz_code_reg)
      else $error("port code not in bits 3 to 5");

   chk_card_off: assert property (ctl_reg[pic_pkg::CTL_CARD] && !freeze_now
      |=> !frz_req_reg)
      else $error("disabled card requested");

   chk_lower_off: assert property (ctl_reg[pic_pkg::CTL_LOWER] && !strap_reg.no_chain && !freeze_now
      |=> !chain_out)
      else $error("lower cards not blocked");

   chk_spare_freeze: assert property (!stable_reg[pic_pkg::LANE_FRZ]
      |=> $stable(frz_req_reg) && $stable(frz_code_reg))
      else $error("state changed under spare freeze");

   chk_nochain_pass: assert property (strap_reg.no_chain && !freeze_now
      |=> chain_out == $past(chain_sync))
      else $error("chain not passed through");

   chk_lower_after: assert property (auto_ev
      |=> ctl_reg[pic_pkg::CTL_LOWER])
      else $error("lower cards not blocked after service");
endmodule
`default_nettype wire

// ### pic_cpu_model.sv
// Behavioural model of the processor card that answers the interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model (
   // Clock.
   input wire logic sys_clk,
   // Lines from the card.
   input wire logic int_req_oe,
   input wire logic [7:0] ack_data_o,
   input wire logic ack_data_oe,
   // Lines to the card.
   output var logic intack_n,
   output var logic chain_in,
   output var logic spare_freeze_n
);
   initial begin
      intack_n = 1'b1;
      chain_in = 1'b1;
      spare_freeze_n = 1'b1;
   end

   // ==========================================================================
   // Acknowledge cycle.
   // Acknowledge is raised once a request is seen or after 60 cycles without one, and the byte is taken once it is driven.
   task automatic ack_start(output logic [7:0] b);
      int n;
      b = 8'hXX;
      for (n = 0; n < 60 && int_req_oe !== 1'b1; n++) begin
         @(posedge sys_clk);
      end
      intack_n <= 1'b0;
      for (n = 0; n < 60 && ack_data_oe !== 1'b1; n++) begin
         @(posedge sys_clk);
      end
      if (ack_data_oe === 1'b1) begin
         b = ack_data_o;
      end
   endtask

   // Ends the acknowledge cycle.
   task automatic ack_end();
      @(posedge sys_clk);
      intack_n <= 1'b1;
   endtask

   // Sets the spare freeze level.
   task automatic set_freeze(input logic v);
      @(posedge sys_clk);
      spare_freeze_n <= v;
   endtask

   // Sets the chain input level.
   task automatic set_chain(input logic v);
      @(posedge sys_clk);
      chain_in <= v;
   endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the priority interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, intack_n, spare_freeze_n, int_req_o, int_req_oe, nmi_req_o, nmi_req_oe;
   logic [7:0] irq_in_n = 8'hFF, cap_n, ack_data_o, b;
   logic ack_data_oe, chain_in, chain_out;
   pic_pkg::pic_strap_t straps = pic_pkg::STRAP_RST;
   int num_errors = 0, total_checks = 0;

   always #25 sys_clk = ~sys_clk;

   pic_card #(.VEC_TABLE(256'h1F1E1D1C1B1A191817161514131211100F0E0D0C0B0A09080706050403020100)) u_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_request_in_n(irq_in_n), .request_captured_out_n(cap_n), .intack_n(intack_n),
      .spare_freeze_n(spare_freeze_n), .int_req_o(int_req_o), .int_req_oe(int_req_oe),
      .nmi_req_o(nmi_req_o), .nmi_req_oe(nmi_req_oe), .ack_data_o(ack_data_o),
      .ack_data_oe(ack_data_oe), .chain_in(chain_in), .chain_out(chain_out), .straps(straps));

   pic_cpu_model u_cpu (.sys_clk(sys_clk), .int_req_oe(int_req_oe || nmi_req_oe), .ack_data_o(ack_data_o),
      .ack_data_oe(ack_data_oe), .intack_n(intack_n), .chain_in(chain_in), .spare_freeze_n(spare_freeze_n));

   // ==========================================================================
   // Shared tasks.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      for (n = 0; n < 50 && pready !== 1'b1; n++) begin
         @(posedge sys_clk);
      end
      if (pready !== 1'b1) begin
         num_errors++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pin(input int i, input logic v);
      @(posedge sys_clk);
      irq_in_n[i] <= v;
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic do_reset(input pic_pkg::pic_strap_t s);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      straps <= s;
      irq_in_n <= 8'hFF;
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
   endtask

   // ==========================================================================
   // Scenarios.
   task automatic t_latch_mask_chain();
      apb(1'b0, 12'h330, 0); chk("poll", 0, rd);
      chk("captured", 8'hFF, cap_n);
      pin(2, 1'b0); chk("held poll", 0, cap_n ^ 8'hFF);
      pin(2, 1'b1); apb(1'b1, 12'h334, 8'hFF); pin(2, 1'b0);
      chk("captured", 8'hFB, cap_n);
      chk("masked req", 0, int_req_oe);
      apb(1'b0, 12'h330, 0); chk("poll masked", 8'h04, rd);
      apb(1'b1, 12'h330, 8'hFF); repeat (4) @(posedge sys_clk);
      chk("req", 1, int_req_oe);
      chk("chain out", 0, chain_out);
      u_cpu.set_chain(1'b0); repeat (8) @(posedge sys_clk);
      chk("no chain req", 0, int_req_oe);
      u_cpu.set_chain(1'b1); apb(1'b1, 12'h338, 1); repeat (4) @(posedge sys_clk);
      chk("card off", 0, int_req_oe);
      apb(1'b1, 12'h338, 0); apb(1'b1, 12'h334, 8'hFB); apb(1'b1, 12'h334, 8'hFF);
      repeat (8) @(posedge sys_clk);
      apb(1'b0, 12'h330, 0); chk("no reset edge", 0, rd);
      pin(2, 1'b1);
   endtask

   task automatic t_ack();
      pin(5, 1'b0); pin(3, 1'b0);
      u_cpu.ack_start(b); chk("restart byte", 8'hDF, b);
      pin(0, 1'b0); chk("frozen byte", 8'hDF, ack_data_o);
      u_cpu.ack_end(); repeat (10) @(posedge sys_clk);
      apb(1'b0, 12'h330, 0); chk("auto clear", 8'h21, rd);
      apb(1'b1, 12'h334, 0); apb(1'b1, 12'h334, 8'hFF); apb(1'b1, 12'h338, 0);
      repeat (8) @(posedge sys_clk); chk("chain back", 1, chain_out);
      irq_in_n <= 8'hFF;
   endtask

   task automatic t_freeze();
      apb(1'b1, 12'h330, 8'h00); u_cpu.set_freeze(1'b0); repeat (6) @(posedge sys_clk);
      pin(4, 1'b0); apb(1'b1, 12'h330, 8'hFF); repeat (4) @(posedge sys_clk);
      chk("frozen req", 0, int_req_oe);
      u_cpu.set_freeze(1'b1); repeat (8) @(posedge sys_clk);
      chk("released req", 1, int_req_oe);
      chk("chain held off", 0, chain_out);
      irq_in_n <= 8'hFF;
   endtask

   task automatic t_port(input logic [7:0] exp);
      apb(1'b1, 12'h334, 8'hFF); apb(1'b1, 12'h330, 8'hFF);
      pin(6, 1'b0); pin(1, 1'b0);
      apb(1'b0, 12'h334, 0); chk("port byte", exp, rd);
      repeat (2) @(posedge sys_clk);
      apb(1'b0, 12'h330, 0); chk("port clear", 8'h40, rd);
      apb(1'b0, 12'h340, 0); chk("bad addr", 1, er);
      apb(1'b0, 12'h33C, 0); chk("spare port", 0, rd);
      chk("spare port err", 0, er);
   endtask

   task automatic t_straps();
      apb(1'b1, 12'h334, 8'hFF); apb(1'b1, 12'h330, 8'hFF);
      pin(7, 1'b0); repeat (4) @(posedge sys_clk);
      chk("nmi oe", 1, nmi_req_oe);
      chk("int oe", 0, int_req_oe);
      chk("open drain", 0, {int_req_o, nmi_req_o});
      chk("chain passes", 1, chain_out);
      u_cpu.ack_start(b); chk("restart low", 8'hFF, b);
      u_cpu.ack_end(); repeat (10) @(posedge sys_clk);
      apb(1'b0, 12'h330, 0); chk("no auto clear", 8'h80, rd);
   endtask

   initial begin
      #2_000_000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      do_reset(pic_pkg::STRAP_RST);
      t_latch_mask_chain();
      t_ack();
      t_freeze();
      do_reset('{vec_sel: 1'b0, vec_group: 2'h0, poll_port: 1'b1, default: 1'b0});
      t_port(8'hCF);
      do_reset('{vec_sel: 1'b1, vec_group: 2'h1, poll_port: 1'b1, default: 1'b0});
      t_port(8'h09);
      do_reset('{use_nmi: 1'b1, no_chain: 1'b1, no_autoclear: 1'b1, default: 1'b0});
      t_straps();
      tally_and_finish();
   end
endmodule
`default_nettype wire
